// ### bench/test_program_flash_read_port.sv
// self-checking bench for the program flash read port
`timescale 1ns/10ps
`default_nettype none

module test_program_flash_read_port;
  localparam int unsigned CPI  = 6;
  localparam logic [31:0] A_DL = {18'h0, flash_read_pkg::IDX_DATA_LOW, 2'h0};
  localparam logic [31:0] A_AL = {18'h0, flash_read_pkg::IDX_ADDR_LOW, 2'h0};
  localparam logic [31:0] A_DH = {18'h0, flash_read_pkg::IDX_DATA_HIGH, 2'h0};
  localparam logic [31:0] A_AH = {18'h0, flash_read_pkg::IDX_ADDR_HIGH, 2'h0};
  localparam logic [31:0] A_CT = {18'h0, flash_read_pkg::IDX_CONTROL, 2'h0};

  logic        core_clk, rst, hsel, hwrite, hreadyout, hresp, codeProtect;
  logic        flashRdEn, flashWrEn, progReq, progWrite, progAck, progRefused;
  logic [31:0] haddr, hwdata, hrdata, rdv;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [12:0] flashAddr, progAddr;
  logic [13:0] flashRdData, flashWrData, progWdata, progRdata, wrData;
  int          fails, samplesChecked, cycles, runLen, lastRun, runs, wrPulses;
  wire logic   hready = hreadyout;

  function automatic logic [13:0] arr_word(input logic [12:0] a);
    return {a[6:0], ~a[12:6]};
  endfunction : arr_word

  // idle array bus shows the inverse so a stale word never looks right
  assign flashRdData = flashRdEn ? arr_word(flashAddr) : ~arr_word(flashAddr);

  program_flash_read_port #(.CLKS_PER_INSTR(CPI)) i_program_flash_read_port (
    .core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .flashAddr(flashAddr),
    .flashRdEn(flashRdEn), .flashRdData(flashRdData), .flashWrEn(flashWrEn),
    .flashWrData(flashWrData), .codeProtect(codeProtect), .progReq(progReq),
    .progWrite(progWrite), .progAddr(progAddr), .progWdata(progWdata),
    .progAck(progAck), .progRefused(progRefused), .progRdata(progRdata)
  );

  always #5 core_clk = ~core_clk;

  task finish_test;
    $display("checks %0d errors %0d", samplesChecked, fails);
    if (fails == 0 && samplesChecked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test

  // array activity monitor and hang guard
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (flashRdEn === 1'b1) begin
      runLen <= runLen + 1;
      if (runLen == 0) runs <= runs + 1;
    end else if (runLen != 0) begin
      lastRun <= runLen;
      runLen  <= 0;
    end
    if (flashWrEn === 1'b1) begin
      wrPulses <= wrPulses + 1;
      wrData   <= flashWrData;
    end
    if (cycles == 4000) begin
      fails++;
      finish_test();
    end
  end

  task check(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
           output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= wr;
    htrans <= flash_read_pkg::HTRANS_NONSEQ;
    do @(posedge core_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hready !== 1'b1);
    rd = hrdata;
    check({31'h0, hresp}, {31'h0, flash_read_pkg::HRESP_OKAY});
  endtask : bus

  task check_reg(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] v;
    bus(1'b0, a, 32'h0, v);
    check(v, exp);
  endtask : check_reg

  // programmer access; request held until the answer is sampled at an edge
  task prog_op(input logic wr, input logic [12:0] a, input logic [13:0] wd,
               output logic ack);
    int n;
    n = 0;
    progReq   <= 1'b1;
    progWrite <= wr;
    progAddr  <= a;
    progWdata <= wd;
    do begin
      @(posedge core_clk);
      n++;
    end while (progAck !== 1'b1 && progRefused !== 1'b1 && n < 20);
    ack = (progAck === 1'b1);
    if (progAck !== 1'b1 && progRefused !== 1'b1) begin
      fails++;
      $display("Error at %0t: programmer got no answer", $time);
    end
    progReq <= 1'b0;
  endtask : prog_op

  logic [31:0] resAddr [7];
  logic [31:0] resExp  [7];
  logic [12:0] coreAddr [3];
  logic [12:0] a, pa;
  logic [13:0] w, pw;
  logic        ack;
  int          r0, wp0;

  initial begin
    core_clk = 1'b0; rst = 1'b1; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0;
    hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0; codeProtect = 1'b0;
    progReq = 1'b0; progWrite = 1'b0; progAddr = 13'h0; progWdata = 14'h0;
    fails = 0; samplesChecked = 0; cycles = 0; runLen = 0; lastRun = 0;
    runs = 0; wrPulses = 0; wrData = 14'h0;
    resAddr  = '{A_DL, A_AL, A_DH, A_AH, A_CT, 32'h0000_0000, 32'h0000_4430};
    resExp   = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h80, 32'h0, 32'h0};
    coreAddr = '{13'h1ABC, 13'h1FFF, 13'h0000};
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++) check_reg(resAddr[i], resExp[i]);
    bus(1'b1, A_AH, 32'hFFFF_FFFF, rdv);
    check_reg(A_AH, 32'h0000_001F);
    bus(1'b1, 32'h0000_0440, 32'h0000_00FF, rdv);
    check_reg(32'h0000_0440, 32'h0);
    for (int i = 0; i < 3; i++) begin
      a = coreAddr[i];
      codeProtect <= (i == 2);
      bus(1'b1, A_AH, {27'h0, a[12:8]}, rdv);
      bus(1'b1, A_AL, {24'h0, a[7:0]}, rdv);
      r0 = runs;
      bus(1'b1, A_CT, 32'h0000_0001, rdv);
      if (i == 0) begin
        bus(1'b1, A_CT, 32'h0, rdv);
        check_reg(A_CT, 32'h0000_0081);
      end
      repeat (2 * CPI + 2) @(posedge core_clk);
      check_reg(A_CT, 32'h0000_0080);
      check(runs, r0 + 1);
      check({31'h0, lastRun >= CPI && lastRun <= 2 * CPI}, 32'h1);
      w = arr_word(a);
      // data bytes belong to hardware; a bus write must not disturb them
      bus(1'b1, A_DL, 32'h0000_00FF, rdv);
      check_reg(A_DL, {24'h0, w[7:0]});
      check_reg(A_DH, {26'h0, w[13:8]});
    end
    for (int p = 0; p < 4; p++) begin
      codeProtect <= (p < 2);
      pa  = {11'h1E2, p[1:0]};
      pw  = {12'hA5A, p[1:0]};
      wp0 = wrPulses;
      r0  = runs;
      @(posedge core_clk);
      prog_op(p[0], pa, pw, ack);
      check({31'h0, ack}, {31'h0, p >= 2});
      if (p[0]) begin
        check(wrPulses, wp0 + (p >= 2));
        if (p >= 2) check({18'h0, wrData}, {18'h0, pw});
      end else begin
        check(runs, r0 + (p >= 2));
        if (p >= 2) check({18'h0, progRdata}, {18'h0, arr_word(pa)});
      end
    end
    check_reg(A_DL, {24'h0, w[7:0]});
    check_reg(A_DH, {26'h0, w[13:8]});
    finish_test();
  end
endmodule : test_program_flash_read_port

`default_nettype wire

// ### design/flash_read_pkg.sv
// constants shared by the program flash read port
package flash_read_pkg;

  // register indices; byte address is four times the index
  localparam logic [11:0] IDX_DATA_LOW  = 12'h10C;
  localparam logic [11:0] IDX_ADDR_LOW  = 12'h10D;
  localparam logic [11:0] IDX_DATA_HIGH = 12'h10E;
  localparam logic [11:0] IDX_ADDR_HIGH = 12'h10F;
  localparam logic [11:0] IDX_CONTROL   = 12'h18C;

  // word widths of the flash array and of the implemented high bytes
  localparam int unsigned FLASH_ADDR_W = 13;
  localparam int unsigned FLASH_DATA_W = 14;
  localparam int unsigned ADDR_HIGH_W  = 5;
  localparam int unsigned DATA_HIGH_W  = 6;

  // control register layout
  localparam int unsigned CTRL_TRIG_BIT = 0;
  localparam logic [7:0]  CTRL_FIXED    = 8'h80;

  // reset values
  localparam logic [7:0]  RST_BYTE      = 8'h00;
  localparam logic [31:0] RST_WORD      = 32'h0000_0000;

  // timing: core clocks per instruction cycle, instruction cycles per read
  localparam int unsigned DEF_CLKS_PER_INSTR = 4;
  localparam int unsigned READ_INSTR_CYCLES  = 2;

  // bus encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'h0;

  // decoded register select of a bus transfer
  typedef enum logic [2:0] {
    SEL_NONE      = 3'b000,
    SEL_DATA_LOW  = 3'b001,
    SEL_ADDR_LOW  = 3'b010,
    SEL_DATA_HIGH = 3'b011,
    SEL_ADDR_HIGH = 3'b100,
    SEL_CONTROL   = 3'b101
  } reg_sel_t;

  typedef enum logic [0:0] {
    RD_IDLE  = 1'b0,
    RD_FETCH = 1'b1
  } read_state_t;

  typedef enum logic [1:0] {
    PG_IDLE  = 2'b00,
    PG_READ  = 2'b01,
    PG_WRITE = 2'b10
  } prog_state_t;

endpackage : flash_read_pkg

// ### design/program_flash_read_port.sv
// program flash read port: AHB-Lite registers, word fetch sequencer, programmer gate
//
// Overview of operation
// - setting control bit 0 starts word read
// - software only sets trigger; hardware clears it
// - fetch occupies the next two instruction cycles
// - data registers hold word until next read
// - data low/high bytes present 14-bit word
// - address high/low bytes form 13-bit address
// - unused upper data/address bits read zero
// - control bit 7 reads one, 6:1 zero
// - internal reads work under any code protection
// - code protection refuses external programmer access
// - flash accesses always transfer whole words
//
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/10ps
`default_nettype none

module program_flash_read_port #(
  parameter int unsigned CLKS_PER_INSTR = flash_read_pkg::DEF_CLKS_PER_INSTR
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // flash array port
  output logic [12:0]      flashAddr,
  output logic             flashRdEn,
  input  wire logic [13:0] flashRdData,
  output logic             flashWrEn,
  output logic [13:0]      flashWrData,
  // code protection and external programmer
  input  wire logic        codeProtect,
  input  wire logic        progReq,
  input  wire logic        progWrite,
  input  wire logic [12:0] progAddr,
  input  wire logic [13:0] progWdata,
  output logic             progAck,
  output logic             progRefused,
  output logic [13:0]      progRdata
);

  localparam int unsigned DIV_W = $clog2(CLKS_PER_INSTR + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CLKS_PER_INSTR - 1);
  localparam logic [1:0] TICK_LAST = 2'(flash_read_pkg::READ_INSTR_CYCLES - 1);

  // register state
  logic [7:0]                                   dataLow_q;
  logic [flash_read_pkg::DATA_HIGH_W-1:0]       dataHigh_q;
  logic [7:0]                                   addrLow_q;
  logic [flash_read_pkg::ADDR_HIGH_W-1:0]       addrHigh_q;
  logic                                         trig_q;

  // bus pipeline
  logic                                         dphValid_q;
  logic                                         dphWrite_q;
  flash_read_pkg::reg_sel_t                     dphSel_q;
  logic                                         rdDone_q;
  logic [31:0]                                  hrdata_q;
  flash_read_pkg::reg_sel_t                     aphSel;
  logic [7:0]                                   readMux;

  // sequencer and flash port
  logic [DIV_W-1:0]                             div_q;
  logic                                         instrTick;
  flash_read_pkg::read_state_t                  rdState_q;
  logic [1:0]                                   tickCnt_q;
  flash_read_pkg::prog_state_t                  pgState_q;
  logic [12:0]                                  flashAddr_q;
  logic                                         flashRdEn_q;
  logic                                         flashWrEn_q;
  logic [13:0]                                  flashWrData_q;
  logic                                         progAck_q;
  logic                                         progRefused_q;
  logic [13:0]                                  progRdata_q;

  logic wrCtrl, trigSet, fetchStart, fetchDone, progTake;

  // address decode; anything not a register is SEL_NONE
  always_comb begin
    aphSel = flash_read_pkg::SEL_NONE;
    if (haddr[31:14] == 18'h00000 && haddr[1:0] == 2'h0) begin
      case (haddr[13:2])
        flash_read_pkg::IDX_DATA_LOW:  aphSel = flash_read_pkg::SEL_DATA_LOW;
        flash_read_pkg::IDX_ADDR_LOW:  aphSel = flash_read_pkg::SEL_ADDR_LOW;
        flash_read_pkg::IDX_DATA_HIGH: aphSel = flash_read_pkg::SEL_DATA_HIGH;
        flash_read_pkg::IDX_ADDR_HIGH: aphSel = flash_read_pkg::SEL_ADDR_HIGH;
        flash_read_pkg::IDX_CONTROL:   aphSel = flash_read_pkg::SEL_CONTROL;
        default:                       aphSel = flash_read_pkg::SEL_NONE;
      endcase
    end
  end

  // address phase capture
  always_ff @(posedge core_clk) begin
    if (rst) begin
      dphValid_q <= 1'b0;
      dphWrite_q <= 1'b0;
      dphSel_q   <= flash_read_pkg::SEL_NONE;
    end else if (hready) begin
      dphValid_q <= hsel && htrans == flash_read_pkg::HTRANS_NONSEQ;
      dphWrite_q <= hwrite;
      dphSel_q   <= aphSel;
    end
  end

  // reads take one wait state so a write just before is always seen
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdDone_q <= 1'b0;
      hrdata_q <= flash_read_pkg::RST_WORD;
    end else if (dphValid_q && !dphWrite_q && !rdDone_q) begin
      rdDone_q <= 1'b1;
      hrdata_q <= {24'h000000, readMux};
    end else begin
      rdDone_q <= 1'b0;
    end
  end

  always_comb begin
    case (dphSel_q)
      flash_read_pkg::SEL_DATA_LOW:  readMux = dataLow_q;
      flash_read_pkg::SEL_ADDR_LOW:  readMux = addrLow_q;
      flash_read_pkg::SEL_DATA_HIGH: readMux = {2'h0, dataHigh_q};
      flash_read_pkg::SEL_ADDR_HIGH: readMux = {3'h0, addrHigh_q};
      flash_read_pkg::SEL_CONTROL:   readMux = flash_read_pkg::CTRL_FIXED | {7'h00, trig_q};
      default:                       readMux = flash_read_pkg::RST_BYTE;
    endcase
  end

  assign hreadyout = !(dphValid_q && !dphWrite_q && !rdDone_q);
  assign hresp     = flash_read_pkg::HRESP_OKAY;
  assign hrdata    = hrdata_q;

  assign wrCtrl  = dphValid_q && dphWrite_q && dphSel_q == flash_read_pkg::SEL_CONTROL;
  assign trigSet = wrCtrl && hwdata[flash_read_pkg::CTRL_TRIG_BIT];

  // address bytes; bits above the 13-bit address are not stored
  always_ff @(posedge core_clk) begin
    if (rst) begin
      addrLow_q  <= flash_read_pkg::RST_BYTE;
      addrHigh_q <= '0;
    end else if (dphValid_q && dphWrite_q) begin
      if (dphSel_q == flash_read_pkg::SEL_ADDR_LOW) begin
        addrLow_q <= hwdata[7:0];
      end
      if (dphSel_q == flash_read_pkg::SEL_ADDR_HIGH) begin
        addrHigh_q <= hwdata[flash_read_pkg::ADDR_HIGH_W-1:0];
      end
    end
  end

  // trigger: a zero write does nothing, and a set beats the hardware clear
  always_ff @(posedge core_clk) begin
    if (rst) begin
      trig_q <= 1'b0;
    end else if (trigSet) begin
      trig_q <= 1'b1;
    end else if (fetchDone) begin
      trig_q <= 1'b0;
    end
  end

  // instruction cycle divider
  always_ff @(posedge core_clk) begin
    if (rst) begin
      div_q <= '0;
    end else if (div_q == DIV_LAST) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + DIV_W'(1);
    end
  end

  assign instrTick = div_q == DIV_LAST;

  // a pending programmer cycle finishes first; core reads ignore protection
  assign fetchStart = rdState_q == flash_read_pkg::RD_IDLE && trig_q
                      && pgState_q == flash_read_pkg::PG_IDLE;
  assign fetchDone  = rdState_q == flash_read_pkg::RD_FETCH && instrTick
                      && tickCnt_q == TICK_LAST;
  assign progTake   = progReq && !trig_q && !progAck_q && !progRefused_q
                      && rdState_q == flash_read_pkg::RD_IDLE
                      && pgState_q == flash_read_pkg::PG_IDLE;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdState_q <= flash_read_pkg::RD_IDLE;
      tickCnt_q <= 2'h0;
    end else begin
      case (rdState_q)
        flash_read_pkg::RD_IDLE: begin
          tickCnt_q <= 2'h0;
          if (fetchStart) begin
            rdState_q <= flash_read_pkg::RD_FETCH;
          end
        end
        flash_read_pkg::RD_FETCH: begin
          if (fetchDone) begin
            rdState_q <= flash_read_pkg::RD_IDLE;
          end else if (instrTick) begin
            tickCnt_q <= tickCnt_q + 2'h1;
          end
        end
        default: rdState_q <= flash_read_pkg::RD_IDLE;
      endcase
    end
  end

  // both bytes from one fetched word, untouched between reads
  always_ff @(posedge core_clk) begin
    if (rst) begin
      dataLow_q  <= flash_read_pkg::RST_BYTE;
      dataHigh_q <= '0;
    end else if (fetchDone) begin
      dataLow_q  <= flashRdData[7:0];
      dataHigh_q <= flashRdData[13:8];
    end
  end

  // programmer access: refused outright while protected
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pgState_q     <= flash_read_pkg::PG_IDLE;
      progAck_q     <= 1'b0;
      progRefused_q <= 1'b0;
      progRdata_q   <= '0;
    end else begin
      progAck_q     <= 1'b0;
      progRefused_q <= 1'b0;
      case (pgState_q)
        flash_read_pkg::PG_IDLE: begin
          if (progTake && codeProtect) begin
            progRefused_q <= 1'b1;
          end else if (progTake) begin
            pgState_q <= progWrite ? flash_read_pkg::PG_WRITE : flash_read_pkg::PG_READ;
          end
        end
        flash_read_pkg::PG_READ: begin
          progRdata_q <= flashRdData;
          progAck_q   <= 1'b1;
          pgState_q   <= flash_read_pkg::PG_IDLE;
        end
        flash_read_pkg::PG_WRITE: begin
          progAck_q <= 1'b1;
          pgState_q <= flash_read_pkg::PG_IDLE;
        end
        default: pgState_q <= flash_read_pkg::PG_IDLE;
      endcase
    end
  end

  // flash port: address latched once so later address writes cannot tear a read
  always_ff @(posedge core_clk) begin
    if (rst) begin
      flashAddr_q   <= '0;
      flashRdEn_q   <= 1'b0;
      flashWrEn_q   <= 1'b0;
      flashWrData_q <= '0;
    end else begin
      flashWrEn_q <= 1'b0;
      if (fetchStart) begin
        flashAddr_q <= {addrHigh_q, addrLow_q};
        flashRdEn_q <= 1'b1;
      end else if (fetchDone) begin
        flashRdEn_q <= 1'b0;
      end else if (progTake && !codeProtect) begin
        flashAddr_q   <= progAddr;
        flashRdEn_q   <= !progWrite;
        flashWrEn_q   <= progWrite;
        flashWrData_q <= progWdata;
      end else if (pgState_q == flash_read_pkg::PG_READ) begin
        flashRdEn_q <= 1'b0;
      end
    end
  end

  assign flashAddr   = flashAddr_q;
  assign flashRdEn   = flashRdEn_q;
  assign flashWrEn   = flashWrEn_q;
  assign flashWrData = flashWrData_q;
  assign progAck     = progAck_q;
  assign progRefused = progRefused_q;
  assign progRdata   = progRdata_q;

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  logic [7:0] fetchCyc_q;
  always_ff @(posedge core_clk) begin
    if (rst || rdState_q == flash_read_pkg::RD_IDLE) begin
      fetchCyc_q <= 8'h00;
    end else if (fetchCyc_q != 8'hFF) begin
      fetchCyc_q <= fetchCyc_q + 8'h01;
    end
  end

  sequence s_trig_write;
    trigSet;
  endsequence
  sequence s_fetch_entry;
    fetchStart ##1 rdState_q == flash_read_pkg::RD_FETCH;
  endsequence

  property p_trig_sets;
    s_trig_write |=> trig_q;
  endproperty
  a_trig_sets: assert property (p_trig_sets) else $error("trigger not set by write");
  property p_zero_write_keeps;
    trig_q && wrCtrl && !hwdata[0] && !fetchDone |=> trig_q;
  endproperty
  a_zero_write_keeps: assert property (p_zero_write_keeps) else $error("zero write cleared trigger");
  property p_done_clears;
    fetchDone && !trigSet |=> !trig_q;
  endproperty
  a_done_clears: assert property (p_done_clears) else $error("trigger not cleared at done");
  property p_two_instr;
    fetchDone |-> fetchCyc_q >= 8'(CLKS_PER_INSTR) && fetchCyc_q < 8'(2 * CLKS_PER_INSTR);
  endproperty
  a_two_instr: assert property (p_two_instr) else $error("fetch length not two instruction cycles");
  property p_data_hold;
    !fetchDone |=> $stable(dataLow_q) && $stable(dataHigh_q);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("data changed outside a read");
  property p_word_load;
    fetchDone |=> {dataHigh_q, dataLow_q} == $past(flashRdData);
  endproperty
  a_word_load: assert property (p_word_load) else $error("data bytes not one word");
  property p_addr_form;
    s_fetch_entry |-> flashRdEn && flashAddr == {$past(addrHigh_q, 1), $past(addrLow_q, 1)};
  endproperty
  a_addr_form: assert property (p_addr_form) else $error("flash address not formed");
  property p_ctrl_read;
    dphValid_q && !dphWrite_q && hreadyout && dphSel_q == flash_read_pkg::SEL_CONTROL
      |-> hrdata[31:1] == 31'h0000_0040;
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("control fixed bits wrong");

  property p_high_zero;
    dphValid_q && !dphWrite_q && hreadyout && (dphSel_q == flash_read_pkg::SEL_DATA_HIGH
      || dphSel_q == flash_read_pkg::SEL_ADDR_HIGH) |-> hrdata[7:6] == 2'h0;
  endproperty
  a_high_zero: assert property (p_high_zero) else $error("unused high bits not zero");

  property p_protect_refuse;
    progTake && codeProtect |=> progRefused && !flashWrEn && !progAck;
  endproperty
  a_protect_refuse: assert property (p_protect_refuse) else $error("protected access not refused");

  property p_internal_any;
    fetchStart |=> rdState_q == flash_read_pkg::RD_FETCH ##[1:16] !trig_q || trigSet;
  endproperty
  a_internal_any: assert property (p_internal_any) else $error("internal read blocked");
endmodule : program_flash_read_port

`default_nettype wire
